// file: rtl/adcs_sequencer.sv
`timescale 1ns/1ps
`include "adcs_map.svh"
// overview of the block
// - apb slave with three byte-wide registers in the low lane
// - control register: done, irq enable, continuous, channel
// - result register: last finished conversion, read only
// - clock register: divider code and source select
// - every apb transfer takes exactly one wait state
// - all state but the divider's lives in one packed struct, one flop
//
// conversion timing
// - a control write only arms a start; the start itself waits
//   for the next converter tick, hence sixteen to seventeen ticks
// - sixteen ticks per conversion: even ticks settle, odd decide
// - the comparator is synchronised, so its answer is two clocks
//   old; bus clock /1 is too fast for a trustworthy code
// - changing the divider while running corrupts the result;
//   nothing here prevents that, software must avoid it
//
// pins
// - the picked pin never drives, whatever the port direction
// - all other pins behave as plain port pins
// - pad levels are synchronised before any port read sees them
//
// limitations
// - wait mode needs no input: the converter just keeps going
// - unused channel codes reach the analog side unchanged
module adcs_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // crystal reference clock, sampled as a level
  input wire logic crystalRefClock,
  // stop mode from the system, same clock domain
  input wire logic stopMode,
  // comparator answer: input at or above trial code
  input wire logic compAbove,
  // shared channel pins and their port logic
  input wire logic [`ADCS_NUM_CH-1:0] pinIn,
  input wire adcs_pkg::adcs_port_in_t portIn,
  output adcs_pkg::adcs_port_out_t portOut,
  // analog side controls
  output adcs_pkg::adcs_analog_t analog,
  // converter interrupt request, level
  output logic convIrq
);
  import adcs_pkg::*;

  adcs_state_t s; // registered state
  adcs_state_t next_s; // next state
  logic srcTick; // one source clock event
  logic convTick; // one converter clock event

  // true when addr hits the given register offset
  function automatic logic isReg(input logic [11:0] addr, input logic [11:0] off);
    isReg = (addr == off);
  endfunction

  // true when channel code picks pin i
  function automatic logic chanHit(input logic [4:0] ch, input int i);
    chanHit = (ch == i[4:0]);
  endfunction

  // source: bus clock every cycle, else crystal rising edge
  always_comb begin
    srcTick = s.clkSrcBus | (s.xtalS2 & ~s.xtalPrev);
  end

  // divider turning source events into converter ticks
  adcs_clk_div u_div (
    .clk(clk),
    .rst_n(rst_n),
    .srcTick(srcTick),
    .divSel(s.clkDiv),
    .convTick(convTick)
  );

  logic apbDone; // transfer completes at this edge
  logic scrWrite; // status/control written
  logic dataRead; // result register read
  logic convDone; // a conversion finished this edge
  logic powerOff; // channel code is all ones
  logic [2:0] bitIdx; // bit under decision
  logic [7:0] t; // trial code being refined
  logic sel; // pin loop: pin picked by converter

  // next state
  always_comb begin
    next_s = s;
    bitIdx = 3'h0;
    t = s.trial;
    sel = 1'b0;
    convDone = 1'b0;
    powerOff = (s.channel == `ADCS_CH_OFF);

    // synchronisers, first stage read only by second
    next_s.xtalS1 = crystalRefClock;
    next_s.xtalS2 = s.xtalS1;
    next_s.xtalPrev = s.xtalS2;
    next_s.cmpS1 = compAbove;
    next_s.cmpS2 = s.cmpS1;
    next_s.pinS1 = pinIn;
    next_s.pinS2 = s.pinS1;

    // apb: one wait state, pready raised in the access phase
    // the read word is built in the first access cycle and held
    // in flops, so prdata comes straight from a register; the
    // cost is the fixed wait state on every transfer
    apbDone = psel & penable & s.pready;
    next_s.pready = psel & penable & ~s.pready;
    scrWrite = apbDone & pwrite & isReg(paddr, `ADCS_SCR_OFFSET);
    dataRead = apbDone & ~pwrite & isReg(paddr, `ADCS_DATA_OFFSET);
    if (psel & penable & ~s.pready) begin
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0;
      if (isReg(paddr, `ADCS_SCR_OFFSET)) begin
        // done reads as zero while the irq is enabled
        next_s.prdata[`ADCS_SCR_DONE_BIT] = s.done & ~s.irqEn;
        next_s.prdata[`ADCS_SCR_IEN_BIT] = s.irqEn;
        next_s.prdata[`ADCS_SCR_CONT_BIT] = s.contEn;
        next_s.prdata[`ADCS_SCR_CH_MSB:`ADCS_SCR_CH_LSB] = s.channel;
      end else if (isReg(paddr, `ADCS_DATA_OFFSET)) begin
        next_s.prdata[7:0] = s.result;
      end else if (isReg(paddr, `ADCS_CLK_OFFSET)) begin
        next_s.prdata[`ADCS_CLK_DIV_MSB:`ADCS_CLK_DIV_LSB] = s.clkDiv;
        next_s.prdata[`ADCS_CLK_SRC_BIT] = s.clkSrcBus;
      end else begin
        // unmapped: error answer, data zero
        next_s.pslverr = 1'b1;
      end
    end

    // register writes take effect at the completing edge
    if (scrWrite) begin
      next_s.irqEn = pwdata[`ADCS_SCR_IEN_BIT];
      next_s.contEn = pwdata[`ADCS_SCR_CONT_BIT];
      next_s.channel = pwdata[`ADCS_SCR_CH_MSB:`ADCS_SCR_CH_LSB];
    end
    if (apbDone & pwrite & isReg(paddr, `ADCS_CLK_OFFSET)) begin
      // changing this mid-conversion corrupts the result
      next_s.clkDiv = pwdata[`ADCS_CLK_DIV_MSB:`ADCS_CLK_DIV_LSB];
      next_s.clkSrcBus = pwdata[`ADCS_CLK_SRC_BIT];
    end

    // conversion sequencer, advanced only on converter ticks
    // stop has priority over ticks: an abort must not be lost
    // even when a tick lands in the same cycle; the pending bit
    // keeps the start so conversions resume once stop is gone
    if (stopMode) begin
      // abort, remember to restart once stop ends
      if (s.conv == CONV_RUN) begin
        next_s.pending = 1'b1;
      end
      next_s.conv = CONV_IDLE;
    end else if (convTick) begin
      case (s.conv)
        CONV_IDLE: begin
          if (s.pending & ~powerOff) begin
            // first converter edge after the write starts it
            next_s.conv = CONV_RUN;
            next_s.phase = 4'h0;
            next_s.trial = `ADCS_TRIAL_START;
            next_s.pending = 1'b0;
          end else if (s.pending) begin
            // powered off: the start is dropped
            next_s.pending = 1'b0;
          end
        end
        CONV_RUN: begin
          // odd phases decide a bit, even phases let it settle
          if (s.phase[0]) begin
            bitIdx = 3'(3'h7 - s.phase[3:1]);
            if (!s.cmpS2) begin
              t[bitIdx] = 1'b0;
            end
            if (bitIdx != 3'h0) begin
              t[bitIdx - 3'h1] = 1'b1;
            end
            next_s.trial = t;
          end
          if (s.phase == `ADCS_LAST_PHASE) begin
            // sixteenth tick: store result, flag completion
            next_s.result = t;
            convDone = 1'b1;
            if (s.contEn & ~powerOff) begin
              // back to back: this tick also starts the next
              next_s.phase = 4'h0;
              next_s.trial = `ADCS_TRIAL_START;
            end else begin
              next_s.conv = CONV_IDLE;
            end
          end else begin
            next_s.phase = s.phase + 4'h1;
          end
        end
        default: begin
          next_s.conv = CONV_IDLE;
        end
      endcase
    end

    // a control write abandons the conversion and rearms a start
    // placed after the sequencer so it overrides the state and pending bit a tick sets;
    // a completion in this very cycle still keeps its result
    if (scrWrite) begin
      next_s.conv = CONV_IDLE;
      next_s.pending = 1'b1;
    end

    // done flag: a completion in the clearing cycle wins
    if (convDone) begin
      next_s.done = 1'b1;
    end else if (scrWrite | dataRead) begin
      next_s.done = 1'b0;
    end
    // irq follows the flag while enabled; same clears apply
    next_s.irq = next_s.done & next_s.irqEn;

    // pin ownership and port read path
    // direction set: the latch is read back, as for any output;
    // direction clear: a picked pin reads zero so the analog
    // level never shows as a digital value, others read the pad
    for (int i = 0; i < `ADCS_NUM_CH; i++) begin
      sel = chanHit(s.channel, i);
      // a picked pin never drives, port writes have no effect on the pad
      next_s.portOut.oe_n[i] = sel | ~portIn.dir[i];
      next_s.portOut.drive[i] = portIn.latch[i];
      if (portIn.dir[i]) begin
        next_s.portOut.readData[i] = portIn.latch[i];
      end else if (sel) begin
        next_s.portOut.readData[i] = 1'b0;
      end else begin
        next_s.portOut.readData[i] = s.pinS2[i];
      end
    end

    // analog mux and comparator controls
    // taken from next_s so the trial code and the active flag
    // reach the comparator in the cycle they take effect
    next_s.analog.channel = s.channel;
    next_s.analog.powerDown = powerOff;
    next_s.analog.sampleActive = (next_s.conv == CONV_RUN);
    next_s.analog.trialCode = next_s.trial;
  end

  // state register
  // reset: channel off, crystal source, divide by one, pins
  // released; only constants here, the reset branch stays simple
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.channel <= `ADCS_CH_OFF;
      s.clkDiv <= `ADCS_CLK_DIV_RESET;
      s.clkSrcBus <= `ADCS_CLK_SRC_RESET;
      s.portOut.oe_n <= '1;
      s.analog.channel <= `ADCS_CH_OFF;
      s.analog.powerDown <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  // no logic between the state register and the pins, so every
  // output is glitch free and settles right after the clock edge
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign portOut = s.portOut;
  assign analog = s.analog;
  assign convIrq = s.irq;
endmodule

// file: rtl/adcs_map.svh
`ifndef ADCS_MAP_SVH
`define ADCS_MAP_SVH

// register byte offsets on the apb side
`define ADCS_SCR_OFFSET 12'h038
`define ADCS_DATA_OFFSET 12'h03c
`define ADCS_CLK_OFFSET 12'h040

// status/control field positions
`define ADCS_SCR_DONE_BIT 7
`define ADCS_SCR_IEN_BIT 6
`define ADCS_SCR_CONT_BIT 5
`define ADCS_SCR_CH_MSB 4
`define ADCS_SCR_CH_LSB 0

// clock register field positions
`define ADCS_CLK_DIV_MSB 7
`define ADCS_CLK_DIV_LSB 5
`define ADCS_CLK_SRC_BIT 4

// reset values
`define ADCS_SCR_RESET 8'h1f
`define ADCS_CLK_RESET 8'h00
`define ADCS_CLK_DIV_RESET 3'h0
`define ADCS_CLK_SRC_RESET 1'b0

// channel codes
`define ADCS_NUM_CH 15
`define ADCS_CH_OFF 5'h1f

// conversion timing, in converter clock ticks, and the first trial code
`define ADCS_CONV_TICKS 16
`define ADCS_LAST_PHASE 4'hf
`define ADCS_TRIAL_START 8'h80

`endif

// file: rtl/adcs_pkg.sv
package adcs_pkg;
  `include "adcs_map.svh"

  // conversion sequencer states
  typedef enum logic {
    CONV_IDLE,
    CONV_RUN
  } adcs_conv_e;

  // port logic feeding the shared pins
  typedef struct packed {
    logic [`ADCS_NUM_CH-1:0] latch;
    logic [`ADCS_NUM_CH-1:0] dir;
  } adcs_port_in_t;

  // pin drive and port read results
  typedef struct packed {
    logic [`ADCS_NUM_CH-1:0] readData;
    logic [`ADCS_NUM_CH-1:0] drive;
    logic [`ADCS_NUM_CH-1:0] oe_n;
  } adcs_port_out_t;

  // controls toward the analog mux and comparator
  typedef struct packed {
    logic powerDown;
    logic sampleActive;
    logic [4:0] channel;
    logic [7:0] trialCode;
  } adcs_analog_t;

  // divider state
  typedef struct packed {
    logic [3:0] count;
    logic tick;
  } adcs_div_t;

  // full sequencer state
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic irqEn;
    logic contEn;
    logic [4:0] channel;
    logic [2:0] clkDiv;
    logic clkSrcBus;
    logic done;
    logic irq;
    logic [7:0] result;
    adcs_conv_e conv;
    logic pending;
    logic [3:0] phase;
    logic [7:0] trial;
    logic xtalS1;
    logic xtalS2;
    logic xtalPrev;
    logic cmpS1;
    logic cmpS2;
    logic [`ADCS_NUM_CH-1:0] pinS1;
    logic [`ADCS_NUM_CH-1:0] pinS2;
    adcs_port_out_t portOut;
    adcs_analog_t analog;
  } adcs_state_t;
endpackage

// file: rtl/adcs_clk_div.sv
`timescale 1ns/1ps
// converter clock prescaler: counts source ticks, emits one-cycle ticks
module adcs_clk_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic srcTick,
  input wire logic [2:0] divSel,
  output logic convTick
);
  import adcs_pkg::*;

  adcs_div_t s;
  adcs_div_t next_s;
  logic [3:0] limit; // last count before a tick

  // divide by 1, 2, 4, 8, any code with top bit set gives 16
  always_comb begin
    case (divSel)
      3'h0: limit = 4'h0;
      3'h1: limit = 4'h1;
      3'h2: limit = 4'h3;
      3'h3: limit = 4'h7;
      default: limit = 4'hf;
    endcase
  end

  // count source ticks, wrap at the limit
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (srcTick) begin
      if (s.count >= limit) begin
        // >= so a smaller divider picked mid-count cannot stall
        next_s.count = 4'h0;
        next_s.tick = 1'b1;
      end else begin
        next_s.count = s.count + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign convTick = s.tick;
endmodule

// file: test/adcs_analog_model.sv
`timescale 1ns/1ps
// far side: channel mux feeding one comparator
module adcs_analog_model (
  input wire logic clk,
  input wire adcs_pkg::adcs_analog_t analog,
  output logic compAbove
);
  import adcs_pkg::*;
  logic [7:0] vin; // selected input level, in codes
  logic flip = 1'b0; // junk level while not sampling
  // only the selected source reaches the comparator
  always_comb begin
    case (analog.channel)
      5'h1c, 5'h1d: vin = 8'hff; // supply and high reference
      5'h1e: vin = 8'h00; // low reference
      default: vin = {analog.channel[3:0], analog.channel[3:0]};
    endcase
  end
  // idle output changes every cycle so a stale read shows
  always @(posedge clk) begin
    flip <= ~flip;
  end
  assign compAbove = (analog.powerDown || !analog.sampleActive) ? flip :
    vin >= analog.trialCode;
endmodule

// file: test/adcs_sequencer_assertions.sv
`timescale 1ns/1ps
`include "adcs_map.svh"
// port-level checks for the sequencer
module adcs_sequencer_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stopMode,
  input wire adcs_pkg::adcs_port_in_t portIn,
  input wire adcs_pkg::adcs_port_out_t portOut,
  input wire adcs_pkg::adcs_analog_t analog,
  input wire logic convIrq
);
  import adcs_pkg::*;
  logic xfer; // completing apb edge
  logic wrCtl;
  logic rdCtl;
  logic rdDat;
  logic [7:0] sh; // last control value written
  logic [3:0] stab; // cycles since then, saturating
  logic [14:0] dirQ; // direction one cycle ago
  logic [14:0] rdExp; // picked-pin read value one cycle ago
  assign xfer = psel && penable && pready;
  assign wrCtl = xfer && pwrite && paddr == `ADCS_SCR_OFFSET;
  assign rdCtl = xfer && !pwrite && paddr == `ADCS_SCR_OFFSET;
  assign rdDat = xfer && !pwrite && paddr == `ADCS_DATA_OFFSET;
  // shadow of control so pin checks know the selection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh <= `ADCS_SCR_RESET;
      stab <= 4'h0;
      dirQ <= 15'h0;
      rdExp <= 15'h0;
    end else begin
      dirQ <= portIn.dir;
      rdExp <= portIn.dir & portIn.latch;
      if (wrCtl) begin
        sh <= pwdata[7:0];
        stab <= 4'h0;
      end else if (stab != 4'hf) begin
        stab <= stab + 4'h1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_READY_ONE_WAIT:
    assert property (psel && penable && !pready |=> pready ##1 !pready) else $error("apb ready");
  AST_DONE_HIDDEN:
    assert property (rdCtl && sh[6] |-> !prdata[7]) else $error("done seen with irq on");
  AST_IRQ_GONE:
    assert property ((wrCtl || rdDat) && !analog.sampleActive |=> !convIrq) else $error("irq");
  AST_IRQ_ENABLED:
    assert property ($rose(convIrq) |-> sh[6]) else $error("irq while disabled");
  AST_PICKED_PIN:
    assert property (stab > 4'h2 && sh[4:0] < 5'd15 |-> portOut.oe_n[sh[4:0]] &&
      portOut.readData[sh[4:0]] == rdExp[sh[4:0]]) else $error("picked pin");
  AST_OTHER_PINS:
    assert property (stab > 4'h2 |-> ((portOut.oe_n ^ ~dirQ) & ~(15'h1 << sh[4:0])) == 15'h0)
    else $error("port pin drive");
  AST_OFF:
    assert property (stab > 4'h2 && sh[4:0] == `ADCS_CH_OFF |->
      analog.powerDown && !analog.sampleActive) else $error("not powered off");
  AST_STOP_IDLE:
    assert property (stopMode [*3] |-> !analog.sampleActive) else $error("runs in stop");
  AST_FIRST_TRIAL:
    assert property ($rose(analog.sampleActive) |-> analog.trialCode == 8'h80) else $error("msb");
  cover property ($rose(convIrq));
  cover property (stopMode && analog.sampleActive);
  cover property (wrCtl && analog.sampleActive);
endmodule
bind adcs_sequencer adcs_sequencer_assertions i_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .stopMode(stopMode), .portIn(portIn),
  .portOut(portOut), .analog(analog), .convIrq(convIrq));

// file: test/adcs_sequencer_tb.sv
`timescale 1ns/1ps
`include "adcs_map.svh"
// self-checking bench for the conversion sequencer
module adcs_sequencer_tb;
  import adcs_pkg::*;
  localparam logic [11:0] SCR = `ADCS_SCR_OFFSET;
  localparam logic [11:0] DAT = `ADCS_DATA_OFFSET;
  localparam logic [11:0] CKR = `ADCS_CLK_OFFSET;
  // clock setup, channel, clk cycles per converter tick
  typedef struct {logic [7:0] ck; logic [4:0] ch; int per;} adcs_row_t;
  // channel fourteen is used only because no timer clock runs here
  adcs_row_t rows [6] = '{'{8'h50, 5'h00, 4}, '{8'h70, 5'h07, 8}, '{8'h90, 5'h0e, 16},
    '{8'hf0, 5'h1d, 16}, '{8'h00, 5'h1e, 8}, '{8'h20, 5'h1c, 16}};
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic crystalRefClock = 1'b0;
  logic stopMode, compAbove, convIrq, rderr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdq;
  logic [14:0] pinIn;
  logic [2:0] xc = 3'h0; // crystal divider, period eight clocks
  logic [4:0] c;
  adcs_port_in_t portIn;
  adcs_port_out_t portOut;
  adcs_analog_t analog;
  int nFail, comparisons, n, p;
  adcs_sequencer i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystalRefClock(crystalRefClock), .stopMode(stopMode),
    .compAbove(compAbove), .pinIn(pinIn), .portIn(portIn), .portOut(portOut),
    .analog(analog), .convIrq(convIrq));
  adcs_analog_model i_ana (.clk(clk), .analog(analog), .compAbove(compAbove));
  always #5 clk = ~clk;
  // slow crystal level, unrelated to the apb traffic
  always @(posedge clk) begin
    xc <= xc + 3'h1;
    crystalRefClock <= xc[2];
  end
  // expected code of each source
  function automatic logic [31:0] ex(input logic [4:0] ch);
    if (ch == 5'h1c || ch == 5'h1d) return 32'hff;
    if (ch == 5'h1e) return 32'h0;
    return {24'h0, ch[3:0], ch[3:0]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one transfer, entered and left just after a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdq = prdata;
    rderr = pslverr;
    if (k == 20) nFail++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // poll control until the done flag shows
  task waitDone;
    int k;
    k = 0;
    do begin
      apb(0, SCR, 0);
      k++;
    end while (rdq[7] !== 1'b1 && k < 80);
    if (k == 80) nFail++;
  endtask
  task stopTest;
    if (nFail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    clk = 0;
    rst_n = 0;
    {psel, penable, pwrite, stopMode, paddr, pwdata} = '0;
    portIn = '{latch: 15'h7fff, dir: 15'h00f0};
    pinIn = 15'h2aaa;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // each row: interrupt-driven conversion at one clock setting
    foreach (rows[i]) begin
      c = rows[i].ch;
      p = rows[i].per;
      apb(1, CKR, {24'h0, rows[i].ck});
      apb(1, SCR, {27'h2, c});
      n = 0;
      while (convIrq !== 1'b1 && n < 400) begin
        @(posedge clk);
        n++;
      end
      chk(n >= 16 * p - 2 && n <= 17 * p + 8, 1);
      apb(0, SCR, 0);
      chk(rdq, {27'h2, c});
      apb(0, DAT, 0);
      chk(rdq, ex(c));
      chk(convIrq, 0);
      if (c < 15) chk(portOut.readData[c], portIn.dir[c]);
      chk(portOut.drive, portIn.latch);
    end
    // continuous mode keeps overwriting
    apb(1, CKR, 32'h50);
    apb(1, SCR, 32'h22);
    waitDone;
    apb(0, DAT, 0);
    chk(rdq, 32'h22);
    apb(0, SCR, 0);
    chk(rdq, 32'h22);
    waitDone;
    chk(rdq[7], 1);
    apb(1, SCR, 32'h02);
    apb(0, SCR, 0);
    chk(rdq, 32'h02);
    waitDone;
    apb(0, DAT, 0);
    repeat (200) @(posedge clk);
    apb(0, SCR, 0);
    chk(rdq, 32'h02);
    // new write abandons the running conversion
    apb(1, SCR, 32'h04);
    repeat (30) @(posedge clk);
    apb(1, SCR, 32'h06);
    waitDone;
    apb(0, DAT, 0);
    chk(rdq, 32'h66);
    // stop in mid-conversion, then resume
    apb(1, SCR, 32'h01);
    repeat (20) @(posedge clk);
    stopMode <= 1'b1;
    repeat (150) @(posedge clk);
    apb(0, SCR, 0);
    chk(rdq, 32'h01);
    stopMode <= 1'b0;
    // first result after stop is awaited in full before use
    waitDone;
    apb(0, DAT, 0);
    chk(rdq, 32'h11);
    // power down when the converter is not needed
    apb(1, SCR, 32'h1f);
    apb(0, SCR, 0);
    chk(rdq, 32'h1f);
    // second reset, register defaults, unmapped place
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(0, SCR, 0);
    chk(rdq, 32'h1f);
    apb(0, 12'h044, 0);
    chk({rderr, rdq[30:0]}, 32'h80000000);
    stopTest;
  end
  // hang guard, well past the longest expected run
  initial begin
    repeat (30000) @(posedge clk);
    nFail++;
    stopTest;
  end
endmodule
